// ---- hw/agp_gpio_ctrl.sv ----
// general-purpose pin, mux select, sync and error pin control
// Operation
// - config at 0x06, resets to 0x0800
// - upper outputs driven when enabled or under mux control
// - mux control drives four pins as selects
// - per-channel input pair stays per channel
// - at most 16 channels per mux group
// - programmable settle delay after each switch
// - sync pin is input only when enabled
// - normal sync low holds converter in reset
// - alternate sync only with several channels
// - alternate sync low withholds next conversion
// - sync high releases withheld conversion
// - two-bit field selects error pin mode
// - mode 01: active-low error input
// - mode 10: open-drain error output
// - mode 11: output follows level bit
// - level bit drives or reads pin
`timescale 1ns/1ps
module agp_gpio_ctrl
    import agp_pkg::*;
#(
    parameter int CHAN_W = 4,
    parameter int DLY_W = 8,
    parameter int CONV_CYCLES = 16
) (
    // clocking
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    // sequencer side
    input wire logic [15:0] chanEnable,
    input wire logic [3:0] chanPair [16],
    input wire logic otherErrors,
    output logic [3:0] activePair,
    output logic convActive,
    output logic convReset,
    output logic groupDone,
    // pins
    input wire logic syncPin,
    input wire logic errPinIn,
    output logic errPinOut,
    output logic errPinOeN,
    output logic [1:0] ioPinOut,
    output logic [1:0] ioPinOeN,
    output logic outputPinTwo,
    output logic outputPinThree,
    output logic upperOeN,
    // interrupt
    output logic irq
);
    localparam int CNT_W = $clog2(CONV_CYCLES + 1);

    typedef struct packed {
        logic [15:0] cfg;
        logic altSyncSelect;
        logic [DLY_W-1:0] delay;
        logic [15:0] rdata;
        logic [2:0] irqStat;
        logic [2:0] irqEn;
        agp_seq_e state;
        logic [CHAN_W-1:0] chan;
        logic [CHAN_W-1:0] muxPos;
        logic [DLY_W-1:0] dlyCnt;
        logic [CNT_W-1:0] convCnt;
        logic [3:0] pair;
        logic active;
        logic rst;
        logic done;
        logic [3:0] sel;
        logic selOeN;
        logic upOeN;
        logic errOut;
        logic errOeN;
        logic irqOut;
    } agp_ctrl_s;

    agp_ctrl_s st_reg, st_next;
    logic syncSync;
    logic errSync;

    // pins enter through two flops; nothing else reads the first one
    agp_sync2 u_sync (
        .sysClk(sys_clk),
        .reset(reset),
        .clkEn(clkEn),
        .pinIn(syncPin),
        .pinOut(syncSync)
    );

    agp_sync2 u_err (
        .sysClk(sys_clk),
        .reset(reset),
        .clkEn(clkEn),
        .pinIn(errPinIn),
        .pinOut(errSync)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0] errMode;
        logic syncOn;
        logic multiChan;
        logic altMode;
        logic errFlag;
        logic [CHAN_W-1:0] nextChan;
        logic found;
        logic [2:0] events;
        int k;
        errMode = st_reg.cfg[ERR_MODE_HI:ERR_MODE_LO];
        syncOn = st_reg.cfg[SYNC_EN_BIT];
        multiChan = ($countones(chanEnable) > 1);
        altMode = st_reg.altSyncSelect && multiChan;
        errFlag = otherErrors || ((errMode == ERR_IN) && !errSync);
        nextChan = st_reg.chan;
        found = 1'b0;
        events = '0;
        k = 0;
        st_next = st_reg;
        if (clkEn) begin
            // search the next enabled channel after the current one
            for (int i = 1; i <= 16; i++) begin
                k = (int'(st_reg.chan) + i) % 16;
                if (!found && chanEnable[k]) begin
                    found = 1'b1;
                    nextChan = CHAN_W'(k);
                end
            end
            // register writes
            if (regWr) begin
                case (regAddr)
                    CFG_ADDR: begin
                        st_next.cfg = (regWdata & CFG_WMASK) |
                            (st_reg.cfg & ~CFG_WMASK);
                    end
                    SEQ_ADDR: begin
                        // the alternate-sync flag owns the top bit, so the
                        // delay field stops one bit below it
                        st_next.altSyncSelect = regWdata[SEQ_ALT_BIT];
                        st_next.delay = DLY_W'(
                            regWdata[SEQ_ALT_BIT-1:SEQ_DLY_LO]);
                    end
                    IRQ_EN_ADDR: st_next.irqEn = regWdata[2:0];
                    default: ;
                endcase
            end
            // in input mode the level bit reflects the pin; the mode after
            // this cycle's write decides, so a write that leaves input mode
            // keeps the level bit it carries
            if (st_next.cfg[ERR_MODE_HI:ERR_MODE_LO] == ERR_IN) begin
                st_next.cfg[ERR_LEVEL_BIT] = errSync;
            end
            // register reads, data valid the next cycle only
            st_next.rdata = '0;
            if (regRd) begin
                case (regAddr)
                    CFG_ADDR: st_next.rdata = st_reg.cfg;
                    SEQ_ADDR: begin
                        st_next.rdata = 16'(st_reg.delay) << SEQ_DLY_LO;
                        st_next.rdata[SEQ_ALT_BIT] = st_reg.altSyncSelect;
                    end
                    IRQ_STAT_ADDR: st_next.rdata = {13'h0, st_reg.irqStat};
                    IRQ_EN_ADDR: st_next.rdata = {13'h0, st_reg.irqEn};
                    default: st_next.rdata = 16'h0;
                endcase
            end
            // sequencer tracking
            st_next.done = 1'b0;
            if (syncOn && !altMode && !syncSync) begin
                // normal sync: converter and filter held in reset
                st_next.state = AGP_IDLE;
                st_next.rst = 1'b1;
                st_next.active = 1'b0;
            end else begin
                st_next.rst = 1'b0;
                case (st_reg.state)
                    AGP_IDLE: begin
                        if (chanEnable != 16'h0) begin
                            st_next.state = AGP_SETTLE;
                            st_next.dlyCnt = st_reg.delay;
                        end
                    end
                    AGP_SETTLE: begin
                        // extra settling after each mux switch
                        if (st_reg.dlyCnt == '0) begin
                            st_next.state = AGP_CONV;
                            st_next.active = 1'b1;
                            st_next.convCnt = CNT_W'(CONV_CYCLES);
                            st_next.pair = chanPair[st_reg.chan];
                        end else begin
                            st_next.dlyCnt = st_reg.dlyCnt - 1'b1;
                        end
                    end
                    AGP_CONV: begin
                        if (st_reg.convCnt <= CNT_W'(1)) begin
                            st_next.active = 1'b0;
                            if (syncOn && altMode && !syncSync) begin
                                st_next.state = AGP_HOLD;
                                events[IRQ_HOLD_BIT] = 1'b1;
                            end else begin
                                st_next.state = AGP_SETTLE;
                                st_next.chan = nextChan;
                                st_next.dlyCnt = st_reg.delay;
                            end
                            if (st_reg.muxPos == CHAN_W'(MUX_GROUP - 1)) begin
                                // host must re-point the pair now
                                st_next.done = 1'b1;
                                events[IRQ_GROUP_BIT] = 1'b1;
                            end
                            // held: keep the position until release
                            if (!(syncOn && altMode && !syncSync)) begin
                                st_next.muxPos = st_reg.muxPos + 1'b1;
                            end
                        end else begin
                            st_next.convCnt = st_reg.convCnt - 1'b1;
                        end
                    end
                    AGP_HOLD: begin
                        if (!(syncOn && altMode) || syncSync) begin
                            st_next.state = AGP_SETTLE;
                            st_next.chan = nextChan;
                            st_next.muxPos = st_reg.muxPos + 1'b1;
                            st_next.dlyCnt = st_reg.delay;
                        end
                    end
                    default: st_next.state = AGP_IDLE;
                endcase
            end
            // nothing enabled: park so a later enable starts from settle
            if (chanEnable == 16'h0) begin
                st_next.state = AGP_IDLE;
                st_next.active = 1'b0;
            end
            // select lines follow mux position
            st_next.sel = 4'(st_next.muxPos);
            st_next.selOeN = !st_next.cfg[EXT_MUX_BIT];
            st_next.upOeN = !(st_next.cfg[UPPER_OE_BIT] ||
                st_next.cfg[EXT_MUX_BIT]);
            // error pin per mode
            case (st_next.cfg[ERR_MODE_HI:ERR_MODE_LO])
                ERR_OD: begin
                    // open drain: only ever pulls low
                    st_next.errOut = 1'b0;
                    st_next.errOeN = !errFlag;
                end
                ERR_GPO: begin
                    st_next.errOut = st_next.cfg[ERR_LEVEL_BIT];
                    st_next.errOeN = 1'b0;
                end
                default: begin
                    st_next.errOut = 1'b0;
                    st_next.errOeN = 1'b1;
                end
            endcase
            // interrupt status: set wins over clear
            events[IRQ_ERR_BIT] = errFlag;
            if (regWr && regAddr == IRQ_CLR_ADDR) begin
                st_next.irqStat = st_reg.irqStat & ~regWdata[2:0];
            end
            st_next.irqStat = st_next.irqStat | events;
            st_next.irqOut = |(st_next.irqStat & st_next.irqEn);
        end
        // reset comes last so it wins even while the clock enable is low
        if (reset) begin
            st_next = '0;
            st_next.cfg = CFG_RESET;
            st_next.state = AGP_IDLE;
            st_next.selOeN = 1'b1;
            st_next.upOeN = 1'b1;
            st_next.errOeN = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_reg <= st_next;
    end

    // ----------------------------------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign regRdata = st_reg.rdata;
    assign activePair = st_reg.pair;
    assign convActive = st_reg.active;
    assign convReset = st_reg.rst;
    assign groupDone = st_reg.done;
    assign ioPinOut = st_reg.sel[1:0];
    assign ioPinOeN = {2{st_reg.selOeN}};
    assign outputPinTwo = st_reg.sel[2];
    assign outputPinThree = st_reg.sel[3];
    assign upperOeN = st_reg.upOeN;
    assign errPinOut = st_reg.errOut;
    assign errPinOeN = st_reg.errOeN;
    assign irq = st_reg.irqOut;
endmodule : agp_gpio_ctrl

// ---- hw/agp_pkg.sv ----
// package: register map, field positions, reset values and mux group size
package agp_pkg;
    localparam logic [3:0] CFG_ADDR = 4'h6;
    localparam logic [3:0] IRQ_STAT_ADDR = 4'h8;
    localparam logic [3:0] IRQ_CLR_ADDR = 4'h9;
    localparam logic [3:0] IRQ_EN_ADDR = 4'ha;
    localparam logic [3:0] SEQ_ADDR = 4'hb;
    localparam logic [15:0] CFG_RESET = 16'h0800;
    localparam logic [15:0] CFG_WMASK = 16'h3f00;
    localparam int UPPER_OE_BIT = 13;
    localparam int EXT_MUX_BIT = 12;
    localparam int SYNC_EN_BIT = 11;
    localparam int ERR_MODE_HI = 10;
    localparam int ERR_MODE_LO = 9;
    localparam int ERR_LEVEL_BIT = 8;
    localparam int SEQ_ALT_BIT = 15;
    localparam int SEQ_DLY_LO = 8;
    localparam logic [1:0] ERR_OFF = 2'h0;
    localparam logic [1:0] ERR_IN = 2'h1;
    localparam logic [1:0] ERR_OD = 2'h2;
    localparam logic [1:0] ERR_GPO = 2'h3;
    localparam int MUX_GROUP = 16;
    localparam int IRQ_GROUP_BIT = 0;
    localparam int IRQ_HOLD_BIT = 1;
    localparam int IRQ_ERR_BIT = 2;
    typedef enum logic [1:0] {AGP_IDLE, AGP_SETTLE, AGP_CONV, AGP_HOLD}
        agp_seq_e;
endpackage : agp_pkg

// ---- hw/agp_sync2.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module agp_sync2 (
    // clocking
    input wire logic sysClk,
    input wire logic reset,
    input wire logic clkEn,
    // data
    input wire logic pinIn,
    output logic pinOut
);
    typedef struct packed {
        logic first;
        logic second;
    } agp_sync_s;
    agp_sync_s st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        if (clkEn) begin
            st_next.first = pinIn;
            st_next.second = st_reg.first;
        end
        if (reset) begin
            st_next = '0;
        end
    end

    always_ff @(posedge sysClk) begin
        st_reg <= st_next;
    end

    assign pinOut = st_reg.second;
endmodule : agp_sync2

// ---- tb/agp_board_model.sv ----
// board model: mux select lines, sync source and shared error wire
`timescale 1ns/1ps
module agp_board_model (
    // pins from the block
    input wire logic [1:0] ioPinOut,
    input wire logic [1:0] ioPinOeN,
    input wire logic outputPinTwo,
    input wire logic outputPinThree,
    input wire logic upperOeN,
    input wire logic errPinOut,
    input wire logic errPinOeN,
    // bench control
    input wire logic syncLevel,
    input wire logic errPull,
    // levels seen on the board
    output logic syncPin,
    output logic errPinIn,
    output logic [3:0] muxSel
);
    logic [3:0] drv;
    logic [3:0] oe;
    assign drv = {outputPinThree, outputPinTwo, ioPinOut};
    assign oe = {~upperOeN, ~upperOeN, ~ioPinOeN};
    // a floating select line reads inverted so it never looks valid
    always_comb begin
        foreach (muxSel[i]) muxSel[i] = oe[i] ? drv[i] : ~drv[i];
    end
    assign syncPin = syncLevel;
    // pull-up holds the wire high unless some device sinks it
    assign errPinIn = ~(errPull | (~errPinOeN & ~errPinOut));
endmodule : agp_board_model

// ---- tb/agp_gpio_ctrl_monitor.sv ----
// checker for the pin control block, bound to its ports
`timescale 1ns/1ps
module agp_gpio_ctrl_monitor
    import agp_pkg::*;
(
    // clocking
    input wire logic sys_clk,
    input wire logic reset,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdata,
    // status and pins
    input wire logic convReset,
    input wire logic groupDone,
    input wire logic syncPin,
    input wire logic errPinOut,
    input wire logic errPinOeN,
    input wire logic [1:0] ioPinOeN,
    input wire logic upperOeN,
    input wire logic irq
);
    logic [15:0] cfgR;
    logic altR;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // shadow of the writable config bits so pin checks know the mode
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cfgR <= CFG_RESET;
            altR <= 1'h0;
        end else if (regWr && regAddr == CFG_ADDR) begin
            cfgR <= regWdata & CFG_WMASK;
        end else if (regWr && regAddr == SEQ_ADDR) begin
            altR <= regWdata[SEQ_ALT_BIT];
        end
    end
    // ----
    // assertions
    // ----
    // outside input mode the whole readback matches the last write
    sequence s_cfg_rd;
        regRd && regAddr == CFG_ADDR && cfgR[10:9] != ERR_IN;
    endsequence
    sequence s_cfg_data;
        regRdata == $past(cfgR);
    endsequence
    a_reset_quiet: assert property ($fell(reset) |->
        upperOeN && errPinOeN && !irq) else $error("outputs after reset");
    a_read_idle: assert property (!regRd |=> regRdata == 16'h0)
        else $error("read data without read");
    a_cfg_readback: assert property (s_cfg_rd |=> s_cfg_data)
        else $error("config readback wrong");
    a_upper_oe: assert property ($stable(cfgR) |-> upperOeN ==
        !(cfgR[UPPER_OE_BIT] || cfgR[EXT_MUX_BIT])) else $error("upper oe");
    a_mux_oe: assert property ($stable(cfgR) && cfgR[EXT_MUX_BIT] |->
        ioPinOeN == 2'h0) else $error("select pins not driven");
    a_err_quiet: assert property ($stable(cfgR) && !cfgR[10] |->
        errPinOeN) else $error("error pin driven as input");
    a_err_gpo: assert property ($stable(cfgR) && cfgR[10:9] == ERR_GPO |->
        !errPinOeN && errPinOut == cfgR[ERR_LEVEL_BIT])
        else $error("error pin output level");
    a_err_od: assert property (cfgR[10:9] == ERR_OD && !errPinOeN |->
        !errPinOut) else $error("open drain drives high");
    a_sync_hold: assert property ((cfgR[SYNC_EN_BIT] && !altR &&
        !syncPin)[*5] |-> convReset) else $error("sync low not holding");
    a_done_pulse: assert property (groupDone |=> !groupDone)
        else $error("group done longer than a pulse");
endmodule : agp_gpio_ctrl_monitor
bind agp_gpio_ctrl agp_gpio_ctrl_monitor u_mon (.sys_clk, .reset, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .convReset, .groupDone, .syncPin,
    .errPinOut, .errPinOeN, .ioPinOeN, .upperOeN, .irq);

// ---- tb/agp_gpio_ctrl_tb.sv ----
// self-checking bench for the pin control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module agp_gpio_ctrl_tb;
    import agp_pkg::*;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic regWr = 1'h0, regRd = 1'h0, otherErrors = 1'h0;
    logic syncLevel = 1'h1, errPull = 1'h0;
    logic [3:0] regAddr = 4'h0, activePair, muxSel, pos;
    logic [15:0] regWdata = 16'h0, chanEnable = 16'hffff, regRdata, d, e;
    logic [3:0] chanPair [16];
    logic convActive, convReset, groupDone, syncPin, errPinIn, errPinOut;
    logic errPinOeN, outputPinTwo, outputPinThree, upperOeN, irq;
    logic [1:0] ioPinOut, ioPinOeN;
    int failures = 0, total_checks = 0, cyc = 0, g;
    always #10 sys_clk = ~sys_clk;
    agp_gpio_ctrl #(.CONV_CYCLES(4)) u_dut (.sys_clk, .reset, .clkEn(1'h1),
        .regAddr, .regWdata, .regWr, .regRd, .regRdata, .chanEnable,
        .chanPair, .otherErrors, .activePair, .convActive, .convReset,
        .groupDone, .syncPin, .errPinIn, .errPinOut, .errPinOeN, .ioPinOut,
        .ioPinOeN, .outputPinTwo, .outputPinThree, .upperOeN, .irq);
    agp_board_model u_board (.ioPinOut, .ioPinOeN, .outputPinTwo,
        .outputPinThree, .upperOeN, .errPinOut, .errPinOeN, .syncLevel,
        .errPull, .syncPin, .errPinIn, .muxSel);
    // ----
    // bus tasks and expectations
    // ----
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wt
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'h1;
        @(posedge sys_clk);
        regWr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge sys_clk);
        regRd <= 1'h0;
        #1 v = regRdata;
    endtask : rd
    task automatic sy(input logic l, input int n);
        @(posedge sys_clk);
        syncLevel <= l;
        wt(n);
    endtask : sy
    // cycles from the end of one conversion to the start of the next
    task automatic nc(output int n);
        n = 0;
        while (convActive === 1'h1) wt(1);
        while (convActive !== 1'h1 && n < 300) begin
            wt(1);
            n++;
        end
    endtask : nc
    // input mode reads back the pin, idle on its pull-up
    function automatic logic [15:0] expCfg(input logic [15:0] v);
        expCfg = v & CFG_WMASK;
        if (v[10:9] == ERR_IN) expCfg[ERR_LEVEL_BIT] = 1'h1;
    endfunction : expCfg
    function automatic logic expPin(input logic [15:0] v);
        expPin = (v[10:9] == ERR_GPO) ? v[ERR_LEVEL_BIT] : 1'h1;
    endfunction : expPin
    task automatic stop_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(32'h3e963300));
        foreach (chanPair[i]) chanPair[i] = 4'($urandom);
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        rd(CFG_ADDR, d);
        `CHK("cfg rst", CFG_RESET, d)
        `CHK("upper oe", 1'h1, upperOeN)
        rd(4'h0, d);
        `CHK("unmapped", 16'h0, d)
        for (int i = 0; i < 28; i++) begin
            d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0 : 16'($urandom);
            wr(CFG_ADDR, d);
            // input mode needs the two pin flops before the level bit settles
            wt(2);
            rd(CFG_ADDR, e);
            `CHK("cfg", expCfg(d), e)
            `CHK("upper oe", ~(d[13] | d[12]), upperOeN)
            `CHK("err pin", expPin(d), errPinIn)
        end
        wr(IRQ_EN_ADDR, 16'h0);
        wr(CFG_ADDR, 16'h0a00);
        wr(IRQ_CLR_ADDR, 16'h7);
        @(posedge sys_clk);
        errPull <= 1'h1;
        wt(6);
        `CHK("irq mask", 1'h0, irq)
        rd(CFG_ADDR, d);
        `CHK("err level", 16'h0a00, d)
        wr(IRQ_EN_ADDR, 16'h4);
        wt(2);
        `CHK("irq", 1'h1, irq)
        @(posedge sys_clk);
        errPull <= 1'h0;
        wt(6);
        wr(IRQ_CLR_ADDR, 16'h4);
        wt(2);
        `CHK("irq clr", 1'h0, irq)
        wr(CFG_ADDR, 16'h0c00);
        @(posedge sys_clk);
        otherErrors <= 1'h1;
        wt(4);
        `CHK("od sink", 1'h0, errPinIn)
        @(posedge sys_clk);
        otherErrors <= 1'h0;
        wt(2);
        wr(IRQ_CLR_ADDR, 16'h7);
        wt(3);
        `CHK("od free", 1'h1, errPinIn)
        wr(SEQ_ADDR, 16'h0500);
        wr(CFG_ADDR, 16'h1800);
        repeat (2) begin
            @(posedge sys_clk);
            foreach (chanPair[i]) chanPair[i] <= 4'($urandom);
            wr(IRQ_CLR_ADDR, 16'h7);
            nc(g);
            nc(g);
            `CHK("mux oe", 4'h0, {upperOeN, upperOeN, ioPinOeN})
            for (int i = 0; i < 17; i++) begin
                pos = muxSel;
                `CHK("pair", chanPair[pos], activePair)
                nc(g);
                `CHK("sel step", pos + 4'h1, muxSel)
                `CHK("settle", 1'h1, g >= 5)
            end
            rd(IRQ_STAT_ADDR, d);
            `CHK("group", 1'h1, d[IRQ_GROUP_BIT])
        end
        sy(1'h0, 8);
        `CHK("sync hold", 1'h1, convReset)
        `CHK("no conv", 1'h0, convActive)
        sy(1'h1, 8);
        `CHK("sync free", 1'h0, convReset)
        wr(CFG_ADDR, 16'h1000);
        sy(1'h0, 8);
        `CHK("sync off", 1'h0, convReset)
        sy(1'h1, 1);
        wr(CFG_ADDR, 16'h1800);
        wr(SEQ_ADDR, 16'h8100);
        wr(IRQ_CLR_ADDR, 16'h7);
        sy(1'h0, 40);
        `CHK("alt no rst", 1'h0, convReset)
        `CHK("alt held", 1'h0, convActive)
        sy(1'h1, 0);
        nc(g);
        `CHK("alt go", 1'h1, g < 20)
        rd(IRQ_STAT_ADDR, d);
        `CHK("held flag", 1'h1, d[IRQ_HOLD_BIT])
        @(posedge sys_clk);
        chanEnable <= 16'h1;
        sy(1'h0, 8);
        `CHK("alt single", 1'h1, convReset)
        stop_test();
    end
endmodule : agp_gpio_ctrl_tb
